/* logic/iaod_pkg.sv */
// Constants and state type for the information-area overlay decode
package iaod_pkg;

	// ==========================================================
	// Overlay window and enable
	localparam logic [2:0] IAOD_ENABLE_BIT = 3'h7;
	localparam logic [15:0] IAOD_OVL_LO = 16'hFE00;
	localparam logic [15:0] IAOD_OVL_HI = 16'hFF7F;
	localparam int IAOD_INFO_SIZE = 128;

	// ==========================================================
	// Information-area layout, as byte offsets from the window base, plus the absolute reserved addresses and fill bytes
	localparam int IAOD_OPT_LO = 'h00;
	localparam int IAOD_OPT_LEN = 64;
	localparam int IAOD_PN_LO = 'h40;
	localparam int IAOD_PN_LEN = 20;
	localparam int IAOD_RSV_LO = 'h54;
	localparam int IAOD_CAL_LO = 'h60;
	localparam int IAOD_CAL_LEN = 32;
	localparam logic [15:0] IAOD_RSV_ADDR_LO = 16'hFE54;
	localparam logic [15:0] IAOD_RSV_ADDR_HI = 16'hFE5F;
	localparam logic [7:0] IAOD_PN_PAD = 8'hFF;
	localparam logic [7:0] IAOD_RSV_VAL = 8'hFF;

	// ==========================================================
	// Data memory space: nothing behind it
	localparam logic [7:0] IAOD_DM_FILL = 8'h00;

	// ==========================================================
	// Reset values and registered state
	localparam logic [7:0] IAOD_DATA_RST = 8'h00;
	localparam logic [15:0] IAOD_ADDR_RST = 16'h0000;

	typedef struct packed {
		logic rd_valid;
		logic [7:0] rd_data;
		logic rd_info;
		logic pm_wr_req;
		logic [15:0] pm_wr_addr;
		logic [7:0] pm_wr_data;
		logic wr_refused;
		logic dm_ack;
	} iaod_state_t;

endpackage : iaod_pkg

/* logic/iaod_rom_if.sv */
// Index and byte between the decode and the information store
`timescale 1ns/1ps
interface iaod_rom_if;
	logic [6:0] index;
	logic [7:0] data;
	modport user (output index, input data);
	modport store (input index, output data);
endinterface : iaod_rom_if

/* logic/iaod_info_rom.sv */
// Read-only information-area store, contents fixed by parameters
`timescale 1ns/1ps
module iaod_info_rom import iaod_pkg::*; #(
	// Arbitrary neutral contents, not tied to any real part
	parameter logic [8*IAOD_OPT_LEN-1:0] OPT_INIT = '1,
	parameter logic [8*IAOD_PN_LEN-1:0] PART_STR = {"IAOD0001", {12{IAOD_PN_PAD}}},
	parameter logic [8*IAOD_CAL_LEN-1:0] CAL_INIT = '0
) (
	iaod_rom_if.store rom
);
	logic [7:0] table_b [IAOD_INFO_SIZE];

	// ==========================================================
	// Byte table
	// RULE5 - layout of bytes
	for (genvar i = 0; i < IAOD_INFO_SIZE; i++) begin : g_byte
		if (i < IAOD_PN_LO) begin : g_opt
			assign table_b[i] = OPT_INIT[8*(i-IAOD_OPT_LO) +: 8];
		end else if (i < IAOD_RSV_LO) begin : g_pn
			// First character sits in the top byte, so the string is left-justified
			assign table_b[i] = PART_STR[8*(IAOD_PN_LEN-1-(i-IAOD_PN_LO)) +: 8];
		end else if (i < IAOD_CAL_LO) begin : g_rsv
			assign table_b[i] = IAOD_RSV_VAL;
		end else begin : g_cal
			assign table_b[i] = CAL_INIT[8*(i-IAOD_CAL_LO) +: 8];
		end
	end

	// RULE4 - no write path
	assign rom.data = table_b[rom.index];

endmodule : iaod_info_rom

/* logic/iaod_top.sv */
// Program-memory read decode with information-area overlay
// Summary of operation
// RULE1 - The overlay is enabled only while bit 7 of the page select value is 1.
// RULE2 - When enabled, the 128-byte information area overlays addresses FE00H to FF7FH.
// RULE3 - Overlaid reads return information-area bytes instead of program memory bytes.
// RULE4 - The information area is read-only; writes aimed at it are refused.
// RULE5 - Layout: options FE00-FE3F, part string FE40-FE53, reserved FE54-FE5F, cal FE60-FE7F.
// RULE6 - The data memory space is not decoded and reaches no storage.
// RULE7 - With the enable bit at 0, overlaid addresses read ordinary program memory.
`timescale 1ns/1ps
module iaod_top import iaod_pkg::*; #(
	parameter int ADDR_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] page_sel,
	input wire logic rd_req,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic rd_info,
	output logic pm_rd_req,
	output logic [ADDR_W-1:0] pm_rd_addr,
	input wire logic [7:0] pm_rd_data,
	input wire logic wr_req,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	output logic pm_wr_req,
	output logic [ADDR_W-1:0] pm_wr_addr,
	output logic [7:0] pm_wr_data,
	output logic wr_refused,
	input wire logic dm_req,
	input wire logic [ADDR_W-1:0] dm_addr,
	output logic [7:0] dm_rd_data,
	output logic dm_ack
);
	iaod_state_t q;
	iaod_state_t d;
	iaod_rom_if rom ();
	logic ovl_en;
	logic rd_hit;
	logic wr_hit;
	logic in_info;
	logic [ADDR_W-1:0] rd_off;

	iaod_info_rom u_rom (
		.rom (rom)
	);

	// ==========================================================
	// Decode
	// RULE1 - enable from bit
	assign ovl_en = page_sel[IAOD_ENABLE_BIT];
	// RULE2 - window hit test
	assign rd_hit = ovl_en && (rd_addr >= IAOD_OVL_LO) && (rd_addr <= IAOD_OVL_HI);
	assign wr_hit = ovl_en && (wr_addr >= IAOD_OVL_LO) && (wr_addr <= IAOD_OVL_HI);
	assign rd_off = rd_addr - IAOD_OVL_LO;
	// Window is wider than the area; the tail reads as reserved
	assign in_info = rd_off < ADDR_W'(IAOD_INFO_SIZE);
	assign rom.index = rd_off[6:0];

	// RULE7 - miss goes to memory
	assign pm_rd_req = rd_req && !rd_hit;
	assign pm_rd_addr = rd_addr;

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		d.rd_valid = rd_req;
		d.rd_info = 1'b0;
		if (rd_req) begin
			// RULE3 - overlay data select
			if (rd_hit) begin
				d.rd_data = in_info ? rom.data : IAOD_RSV_VAL;
				d.rd_info = 1'b1;
			end else begin
				d.rd_data = pm_rd_data;
			end
		end
		// RULE4 - refuse overlay writes
		d.pm_wr_req = wr_req && !wr_hit;
		d.wr_refused = wr_req && wr_hit;
		if (wr_req && !wr_hit) begin
			d.pm_wr_addr = wr_addr;
			d.pm_wr_data = wr_data;
		end
		// RULE6 - data space answered empty
		d.dm_ack = dm_req;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '{rd_valid: 1'b0, rd_data: IAOD_DATA_RST, rd_info: 1'b0, pm_wr_req: 1'b0,
				pm_wr_addr: IAOD_ADDR_RST, pm_wr_data: IAOD_DATA_RST, wr_refused: 1'b0,
				dm_ack: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign rd_valid = q.rd_valid;
	assign rd_data = q.rd_data;
	assign rd_info = q.rd_info;
	assign pm_wr_req = q.pm_wr_req;
	assign pm_wr_addr = q.pm_wr_addr;
	assign pm_wr_data = q.pm_wr_data;
	assign wr_refused = q.wr_refused;
	assign dm_ack = q.dm_ack;
	// Address is ignored on purpose: no storage behind it
	assign dm_rd_data = IAOD_DM_FILL;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Request shapes
	sequence seq_info_read;
		rd_req && page_sel[IAOD_ENABLE_BIT]
			&& rd_addr >= IAOD_OVL_LO && rd_addr <= IAOD_OVL_HI;
	endsequence

	sequence seq_plain_read;
		rd_req && !page_sel[IAOD_ENABLE_BIT];
	endsequence

	sequence seq_outside_read;
		rd_req && !(rd_addr >= IAOD_OVL_LO && rd_addr <= IAOD_OVL_HI);
	endsequence

	sequence seq_area_read;
		seq_info_read ##0 in_info;
	endsequence

	sequence seq_tail_read;
		seq_info_read ##0 !in_info;
	endsequence

	sequence seq_reserved_read;
		seq_info_read ##0 rd_addr >= IAOD_RSV_ADDR_LO && rd_addr <= IAOD_RSV_ADDR_HI;
	endsequence

	sequence seq_info_write;
		wr_req && page_sel[IAOD_ENABLE_BIT]
			&& wr_addr >= IAOD_OVL_LO && wr_addr <= IAOD_OVL_HI;
	endsequence

	sequence seq_plain_write;
		wr_req && !(page_sel[IAOD_ENABLE_BIT] && wr_addr >= IAOD_OVL_LO
			&& wr_addr <= IAOD_OVL_HI);
	endsequence

	// ==========================================================
	// Read answer and hold
	chk_read_answer: assert property (rd_req |=> rd_valid) // RULE3
		else $error("read not answered next cycle");
	chk_read_pulse: assert property (!rd_req |=> !rd_valid && !rd_info) // RULE3
		else $error("read strobe without a request");
	chk_read_hold: assert property (!rd_req |=> $stable(rd_data)) // RULE3
		else $error("read data changed without a request");
	chk_info_pair: assert property (rd_info |-> rd_valid) // RULE3
		else $error("overlay flag without an answer");

	// ==========================================================
	// Overlay select
	chk_enable_bit: assert property (rd_info |-> $past(page_sel[IAOD_ENABLE_BIT])) // RULE1
		else $error("overlay used with enable bit low");
	chk_overlay_hit: assert property (seq_info_read |=> rd_info) // RULE2
		else $error("window read not served by the overlay");
	chk_overlay_range: assert property (seq_outside_read |=> !rd_info) // RULE2
		else $error("overlay hit outside window");
	chk_hit_no_fetch: assert property (seq_info_read |-> !pm_rd_req) // RULE3
		else $error("overlaid read also fetched program memory");
	chk_overlay_data: assert property (seq_area_read |=> rd_data == $past(rom.data)) // RULE3
		else $error("overlay read returned wrong byte");
	chk_reserved_read: assert property (seq_reserved_read |=> rd_data == IAOD_RSV_VAL) // RULE5
		else $error("reserved byte not padded");
	chk_tail_read: assert property (seq_tail_read |=> // RULE2
		rd_info && rd_data == IAOD_RSV_VAL)
		else $error("window tail not read as reserved");
	chk_miss_data: assert property (seq_outside_read |-> // RULE3
		pm_rd_req ##1 !rd_info && rd_data == $past(pm_rd_data))
		else $error("read outside window did not pass memory data");
	chk_disabled_pass: assert property (seq_plain_read |-> // RULE7
		pm_rd_req ##1 rd_valid && !rd_info && rd_data == $past(pm_rd_data))
		else $error("disabled overlay did not pass memory data");
	chk_miss_address: assert property (seq_outside_read |-> pm_rd_addr == rd_addr) // RULE7
		else $error("memory read address differs from request");

	// ==========================================================
	// Write path checks
	// Refused writes leave the held address and data alone, so nothing downstream sees them
	chk_no_info_write: assert property (seq_info_write |=> wr_refused && !pm_wr_req) // RULE4
		else $error("write reached information area");
	chk_info_unwritten: assert property (seq_info_write |=> // RULE4
		$stable(pm_wr_addr) && $stable(pm_wr_data))
		else $error("refused write moved the write port");
	chk_refuse_cause: assert property (wr_refused |-> // RULE1
		$past(wr_req) && $past(page_sel[IAOD_ENABLE_BIT]))
		else $error("write refused with enable bit low");
	chk_pass_write: assert property (seq_plain_write |=> // RULE4
		pm_wr_req && !wr_refused && pm_wr_addr == $past(wr_addr)
		&& pm_wr_data == $past(wr_data))
		else $error("ordinary write not passed to memory");
	chk_write_quiet: assert property (!wr_req |=> // RULE4
		!pm_wr_req && !wr_refused && $stable(pm_wr_addr) && $stable(pm_wr_data))
		else $error("write port moved without a request");
	chk_write_alone: assert property (wr_req && !rd_req |-> !pm_rd_req) // RULE4
		else $error("write started a memory read");

	// ==========================================================
	// Data space checks
	chk_data_space: assert property (dm_req && !wr_req |=> // RULE6
		dm_ack && dm_rd_data == IAOD_DM_FILL && !pm_wr_req)
		else $error("data space access touched storage");
	chk_data_quiet: assert property (!dm_req |=> !dm_ack) // RULE6
		else $error("data space answer without a request");
	chk_data_no_fetch: assert property (dm_req && !rd_req |-> !pm_rd_req) // RULE6
		else $error("data space access fetched program memory");

endmodule : iaod_top

/* tb/iaod_pm_model.sv */
// Program-memory partner: combinational byte store
`timescale 1ns/1ps
module iaod_pm_model (
	input wire logic ref_clk,
	input wire logic pm_rd_req,
	input wire logic [15:0] pm_rd_addr,
	output logic [7:0] pm_rd_data
);
	logic [7:0] junk_q = 8'h5A;
	// ==========================================
	// Idle bus toggles, so a stale byte never passes
	always @(posedge ref_clk) begin
		junk_q <= ~junk_q;
	end
	assign pm_rd_data = pm_rd_req ? (pm_rd_addr[7:0] ^ pm_rd_addr[15:8] ^ 8'h3C) : junk_q;
endmodule : iaod_pm_model

/* tb/tb_top.sv */
// Self-checking bench for the overlay decode
`timescale 1ns/1ps
module tb_top import iaod_pkg::*;;
	`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
		$display("[FAIL] %s exp %h got %h", n, e, g); end end
	logic ref_clk, rst, rd_req, wr_req, dm_req, rd_valid, rd_info, pm_rd_req;
	logic pm_wr_req, wr_refused, dm_ack;
	logic [7:0] page_sel, wr_data, rd_data, pm_rd_data, pm_wr_data, dm_rd_data;
	logic [15:0] rd_addr, wr_addr, dm_addr, pm_rd_addr, pm_wr_addr;
	int err_count = 0;
	int checked = 0;
	int seed = 32'he8e18a2c;
	int i, r;
	logic [7:0] last_rd = 8'h00;
	logic [15:0] cor [12] = '{16'hFDFF, 16'hFE00, 16'hFE3F, 16'hFE40, 16'hFE47, 16'hFE53,
		16'hFE54, 16'hFE60, 16'hFE7F, 16'hFE80, 16'hFF7F, 16'hFF80};
	localparam logic [159:0] PN = {"IAOD0001", {12{8'hFF}}};
	iaod_top dut (.ref_clk(ref_clk), .rst(rst), .page_sel(page_sel), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .rd_info(rd_info),
		.pm_rd_req(pm_rd_req), .pm_rd_addr(pm_rd_addr), .pm_rd_data(pm_rd_data),
		.wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .pm_wr_req(pm_wr_req),
		.pm_wr_addr(pm_wr_addr), .pm_wr_data(pm_wr_data), .wr_refused(wr_refused),
		.dm_req(dm_req), .dm_addr(dm_addr), .dm_rd_data(dm_rd_data), .dm_ack(dm_ack));
	iaod_pm_model pm (.ref_clk(ref_clk), .pm_rd_req(pm_rd_req), .pm_rd_addr(pm_rd_addr),
		.pm_rd_data(pm_rd_data));
	// ==========================================
	// Expectations
	function automatic logic hit(logic [7:0] ps, logic [15:0] a);
		return ps[7] && a >= IAOD_OVL_LO && a <= IAOD_OVL_HI;
	endfunction : hit
	function automatic logic [7:0] exp_rd(logic [7:0] ps, logic [15:0] a);
		logic [15:0] o;
		o = a - 16'hFE00;
		if (!hit(ps, a)) return a[7:0] ^ a[15:8] ^ 8'h3C;
		if (o < 16'h40 || (o >= 16'h54 && o < 16'h60) || o >= 16'h80) return 8'hFF;
		if (o < 16'h54) return PN[8*(19-(o-16'h40)) +: 8];
		return 8'h00;
	endfunction : exp_rd
	task automatic conclude;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// ==========================================
	// One request of kind 0 read, 1 write, 2 data space
	task automatic op(logic [7:0] ps, int k, logic [15:0] a);
		logic [7:0] d;
		d = 8'($random(seed));
		@(posedge ref_clk);
		page_sel <= ps; rd_req <= (k == 0); wr_req <= (k == 1); dm_req <= (k == 2);
		rd_addr <= a; wr_addr <= a; dm_addr <= a; wr_data <= d;
		#1 `CHK("pm_rd_req", k == 0 && !hit(ps, a), pm_rd_req)
		`CHK("pm_rd_addr", a, pm_rd_addr)
		@(posedge ref_clk);
		rd_req <= 1'b0; wr_req <= 1'b0; dm_req <= 1'b0;
		#1;
		`CHK("strobes", {k == 0, k == 2}, {rd_valid, dm_ack})
		if (k == 0) begin
			`CHK("rd_valid", 1'b1, rd_valid)
			`CHK("rd_info", hit(ps, a), rd_info)
			`CHK("rd_data", exp_rd(ps, a), rd_data)
			`CHK("wr_pulses", 2'h0, {wr_refused, pm_wr_req})
			last_rd = exp_rd(ps, a);
		end else if (k == 1) begin
			`CHK("wr_refused", hit(ps, a), wr_refused)
			`CHK("pm_wr_req", !hit(ps, a), pm_wr_req)
			if (!hit(ps, a)) `CHK("pm_wr", {a, d}, {pm_wr_addr, pm_wr_data})
			`CHK("rd_data_hold", last_rd, rd_data)
		end else begin
			`CHK("dm_ack", 1'b1, dm_ack)
			`CHK("dm_rd_data", IAOD_DM_FILL, dm_rd_data)
			`CHK("wr_pulses", 2'h0, {wr_refused, pm_wr_req})
			`CHK("rd_data_hold", last_rd, rd_data)
		end
	endtask : op
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		rst = 1'b1; page_sel = 8'h00; rd_req = 1'b0; wr_req = 1'b0; dm_req = 1'b0;
		rd_addr = 16'h0000; wr_addr = 16'h0000; dm_addr = 16'h0000; wr_data = 8'h00;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		// Each window edge: reads with the enable bit set and clear (other bits set), then a write and a data-space access with it set
		for (i = 0; i < 12; i++) begin
			op(8'h80, 0, cor[i]);
			op(8'h7F, 0, cor[i]);
			op(8'h80, 1, cor[i]);
			op(8'h80, 2, cor[i]);
		end
		// Mid-run reset clears every registered output
		@(posedge ref_clk);
		rst <= 1'b1;
		@(posedge ref_clk);
		#1 `CHK("rst_rd", 10'h0, {rd_valid, rd_info, rd_data})
		`CHK("rst_wr", 27'h0, {pm_wr_req, wr_refused, dm_ack, pm_wr_addr, pm_wr_data})
		@(posedge ref_clk);
		rst <= 1'b0;
		last_rd = IAOD_DATA_RST;
		for (i = 0; i < 400; i++) begin
			r = $random(seed);
			op(r[7:0], int'(r[9:8]) % 3, {r[10] ? 8'hFE : (r[11] ? 8'hFF : r[23:16]), r[31:24]});
		end
		conclude();
	end
endmodule : tb_top
